// [include/olsa_pkg.sv]
// Constants shared by the optical LED slot acquisition block.
// Assumes a 25 MHz reference clock and an 8-bit register port.
package olsa_pkg;
  // Clock and time base.
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned TICK_NS = 1000;
  localparam int unsigned TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  // Pulse width, slot timing and resolution per pulse-width code.
  localparam int unsigned PW_US [4] = '{69, 118, 215, 411};
  localparam int unsigned SLOT_US [4] = '{427, 525, 720, 1107};
  localparam int unsigned GAP_US [4] = '{358, 407, 505, 696};
  localparam int unsigned RES_BITS [4] = '{15, 16, 17, 18};
  // Sample rates per rate code, and the sample period in cycles.
  localparam int unsigned SPS [8] = '{50, 100, 200, 400, 800, 1000, 1600, 3200};
  localparam int unsigned SAMPLE_CYC [8] = '{CLK_HZ / SPS[0], CLK_HZ / SPS[1],
    CLK_HZ / SPS[2], CLK_HZ / SPS[3], CLK_HZ / SPS[4], CLK_HZ / SPS[5],
    CLK_HZ / SPS[6], CLK_HZ / SPS[7]};
  // Highest rate code allowed per pulse-width code.
  localparam logic [2:0] RATE_MAX_RIR [4] = '{3'h6, 3'h5, 3'h4, 3'h3};
  localparam logic [2:0] RATE_MAX_HR [4] = '{3'h7, 3'h6, 3'h6, 3'h5};
  // ADC full scale per range code and LED current steps.
  localparam int unsigned FS_NA [4] = '{2048, 4096, 8192, 16384};
  localparam int unsigned LED_STEP_UA = 200;
  localparam int unsigned LED_FULL_UA = 51000;
  // Register offsets.
  localparam logic [7:0] ADDR_INT_STAT = 8'h01;
  localparam logic [7:0] ADDR_INT_EN = 8'h03;
  localparam logic [7:0] ADDR_MODE = 8'h09;
  localparam logic [7:0] ADDR_ACQ = 8'h0A;
  localparam logic [7:0] ADDR_LED1 = 8'h0C;
  localparam logic [7:0] ADDR_LED2 = 8'h0D;
  localparam logic [7:0] ADDR_LED3 = 8'h0E;
  localparam logic [7:0] ADDR_SLOT_LO = 8'h11;
  localparam logic [7:0] ADDR_SLOT_HI = 8'h12;
  localparam logic [7:0] ADDR_TEMP_W = 8'h1F;
  localparam logic [7:0] ADDR_TEMP_F = 8'h20;
  localparam logic [7:0] ADDR_TEMP_C = 8'h21;
  // Field positions, masks and reset value.
  localparam int unsigned RANGE_LSB = 5;
  localparam int unsigned RATE_LSB = 2;
  localparam int unsigned TEMP_RDY_BIT = 1;
  localparam int unsigned TEMP_EN_BIT = 0;
  localparam logic [7:0] SLOT_MASK = 8'h77;
  localparam logic [7:0] REG_RST = 8'h00;
  // Mode and slot selector codes.
  localparam logic [2:0] MODE_RED = 3'h2;
  localparam logic [2:0] MODE_RED_IR = 3'h3;
  localparam logic [2:0] MODE_SLOTS = 3'h7;
  localparam logic [2:0] SLOT_RED = 3'h1;
  localparam logic [2:0] SLOT_IR = 3'h2;
  localparam logic [2:0] SLOT_GREEN = 3'h3;
  // Result word layout.
  localparam int unsigned RESULT_W = 18;
  localparam int unsigned WORD_W = 24;
endpackage

// [core/olsa_timebase.sv]
// Microsecond tick and sample-period strobe for the acquisition block.
// Assumes the reference clock rate given in the package.
`timescale 1ns/1ps
module olsa_timebase #(
  parameter int unsigned SAMPLE_CYC [8] = olsa_pkg::SAMPLE_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Control
  input wire logic run,
  input wire logic [2:0] rate_sel,
  // Strobes
  output logic us_tick,
  output logic sample_go
);
  logic [4:0] div_r, div_nxt;
  logic [19:0] samp_r, samp_nxt;
  logic tick_nxt, go_nxt;

  always_comb
  begin
    div_nxt = div_r + 5'h01;
    tick_nxt = 1'b0;
    if (div_r == 5'(olsa_pkg::TICK_CYC - 1))
    begin
      div_nxt = 5'h00;
      tick_nxt = 1'b1;
    end
    samp_nxt = samp_r + 20'h00001;
    go_nxt = 1'b0;
    // A compare by >= keeps a lowered period from running a full wrap.
    if (!run)
      samp_nxt = 20'h00000;
    else if (samp_r >= 20'(SAMPLE_CYC[rate_sel] - 1))
    begin
      samp_nxt = 20'h00000;
      go_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      div_r <= 5'h00;
      samp_r <= 20'h00000;
      us_tick <= 1'b0;
      sample_go <= 1'b0;
    end
    else
    begin
      div_r <= div_nxt;
      samp_r <= samp_nxt;
      us_tick <= tick_nxt;
      sample_go <= go_nxt;
    end
  end
endmodule

// [core/olsa_temp.sv]
// Die-temperature conversion control and result registers.
// Assumes the sensor raises conv_done for one cycle with its result.
`timescale 1ns/1ps
module olsa_temp (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register writes
  input wire logic start_req,
  input wire logic wr_whole,
  input wire logic wr_fraction,
  input wire logic [7:0] wr_data,
  // Sensor
  input wire logic conv_done,
  input wire logic [7:0] whole_in,
  input wire logic [3:0] fraction_in,
  // State and strobes
  output logic busy,
  output logic [7:0] whole,
  output logic [3:0] fraction,
  output logic start,
  output logic complete
);
  logic busy_nxt, start_nxt, cmpl_nxt;
  logic [7:0] whole_nxt;
  logic [3:0] frac_nxt;

  always_comb
  begin
    busy_nxt = busy;
    whole_nxt = whole;
    frac_nxt = fraction;
    start_nxt = 1'b0;
    cmpl_nxt = 1'b0;
    if (wr_whole)
      whole_nxt = wr_data;
    if (wr_fraction)
      frac_nxt = wr_data[3:0];
    // A second request while busy joins the running conversion.
    if (start_req && !busy)
    begin
      busy_nxt = 1'b1;
      start_nxt = 1'b1;
    end
    if (busy && conv_done)
    begin
      busy_nxt = 1'b0;
      whole_nxt = whole_in;
      frac_nxt = fraction_in;
      cmpl_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      busy <= 1'b0;
      whole <= olsa_pkg::REG_RST;
      fraction <= 4'h0;
      start <= 1'b0;
      complete <= 1'b0;
    end
    else
    begin
      busy <= busy_nxt;
      whole <= whole_nxt;
      fraction <= frac_nxt;
      start <= start_nxt;
      complete <= cmpl_nxt;
    end
  end
endmodule

// [core/olsa_acq_top.sv]
// Acquisition control: registers, LED slot sequencer, result words, interrupt.
// Assumes a serial engine on ref_clk that drives the register port, and an
// analog front end whose result is valid on the cycle a pulse ends.
`timescale 1ns/1ps
// Overview of operation
// - Mode 010 red only, 011 red plus IR, 111 slot sequenced; others idle.
// - Range bits 6:5 select 2048 to 16384 nA full scale.
// - Rate bits 4:2 select 50 to 3200 samples per second.
// - Red plus IR sample holds one IR and one red pulse with conversion.
// - An unsupported written rate is stored as the highest allowed rate.
// - Width bits 1:0 select 69 to 411 us, 15 to 18 bits.
// - One common pulse width for all LEDs also sets integration time.
// - Each LED has an eight-bit drive level; zero means off.
// - Slot mode runs four ordered slots; selector picks none, red, IR, green.
// - Each active slot pushes one 3-byte word; a sample is all such words.
// - Temperature whole part is eight-bit two's complement degrees.
// - Four-bit fraction counts 0.0625 degree steps, always added positive.
// - Writing one to convert starts one conversion; bit self-clears on completion.
// - Red plus IR rate limits: 1600, 1000, 800, 400 per width.
// - Heart-rate limits: 3200, 1600, 1600, 1000 per width.
// - Interrupt pin is active-low open drain, driven while an enabled flag stands.
// - Slot rising edges are 427, 525, 720 or 1107 us apart, plus 1 us for each skipped slot between them.
// - Mode sits in bits 2:0; changing it leaves other settings and data.
// - Results are left-justified with the MSB at bit 17.
// - Temperature completion raises the temperature-ready flag.
module olsa_acq_top #(
  parameter int unsigned SAMPLE_CYC [8] = olsa_pkg::SAMPLE_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register port from the serial engine
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Interrupt pin, open drain
  output logic irq_o,
  output logic irq_oe_n,
  // LED drivers
  output logic led_red_on,
  output logic led_ir_on,
  output logic led_green_on,
  output logic [7:0] led_level,
  // Analog front end
  output logic [1:0] adc_range_sel,
  output logic [1:0] pulse_width_sel,
  input wire logic [17:0] adc_result,
  // Result stream
  output logic fifo_wr,
  output logic [23:0] fifo_data,
  // Temperature sensor
  output logic temp_start,
  input wire logic temp_done,
  input wire logic [7:0] temp_whole_in,
  input wire logic [3:0] temp_fraction_in
);
  typedef enum {SEQ_IDLE, SEQ_PICK, SEQ_PULSE, SEQ_GAP} olsa_seq_t;

  logic [2:0] mode_r, mode_nxt;
  logic [6:0] acq_r, acq_nxt;
  logic [7:0] led1_r, led1_nxt, led2_r, led2_nxt, led3_r, led3_nxt;
  logic [7:0] slot_lo_r, slot_lo_nxt, slot_hi_r, slot_hi_nxt;
  logic irq_en_r, irq_en_nxt, flag_r, flag_nxt;
  logic [7:0] rdata_nxt;
  logic us_tick, sample_go, temp_busy, temp_cmpl, run;
  logic [7:0] temp_whole;
  logic [3:0] temp_frac;
  logic [1:0] pw;
  olsa_seq_t st_r, st_nxt;
  logic [1:0] idx_r, idx_nxt, cur_r, cur_nxt, pick;
  logic [10:0] cnt_r, cnt_nxt;
  logic push_nxt;
  logic [23:0] data_nxt;

  function automatic logic mode_ok(input logic [2:0] m);
    return m == olsa_pkg::MODE_RED || m == olsa_pkg::MODE_RED_IR ||
           m == olsa_pkg::MODE_SLOTS;
  endfunction

  function automatic logic [2:0] rate_max(input logic [2:0] m, input logic [1:0] w);
    return (m == olsa_pkg::MODE_RED) ? olsa_pkg::RATE_MAX_HR[w] : olsa_pkg::RATE_MAX_RIR[w];
  endfunction

  // Returns the LED of a slot: 0 none, 1 red, 2 IR, 3 green.
  function automatic logic [1:0] slot_led(input logic [2:0] m, input logic [7:0] lo,
                                          input logic [7:0] hi, input logic [1:0] i);
    logic [2:0] sel;
    sel = 3'h0;
    unique case (i)
      2'h0: sel = lo[2:0];
      2'h1: sel = lo[6:4];
      2'h2: sel = hi[2:0];
      2'h3: sel = hi[6:4];
    endcase
    if (m == olsa_pkg::MODE_RED)
      return (i == 2'h0) ? 2'h1 : 2'h0;
    if (m == olsa_pkg::MODE_RED_IR)
      return (i == 2'h0) ? 2'h1 : ((i == 2'h1) ? 2'h2 : 2'h0);
    if (m == olsa_pkg::MODE_SLOTS && (sel == olsa_pkg::SLOT_RED ||
        sel == olsa_pkg::SLOT_IR || sel == olsa_pkg::SLOT_GREEN))
      return sel[1:0];
    return 2'h0;
  endfunction

  function automatic logic [17:0] res_mask(input logic [1:0] w);
    return 18'h3FFFF << (2'h3 - w);
  endfunction

  assign run = mode_ok(mode_r);
  assign pw = acq_r[1:0];
  assign adc_range_sel = acq_r[olsa_pkg::RANGE_LSB +: 2];
  assign pulse_width_sel = acq_r[1:0];
  assign irq_o = 1'b0;

  olsa_timebase #(
    .SAMPLE_CYC(SAMPLE_CYC)
  ) u_timebase (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .run(run),
    .rate_sel(acq_r[olsa_pkg::RATE_LSB +: 3]),
    .us_tick(us_tick),
    .sample_go(sample_go)
  );

  olsa_temp u_temp (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .start_req(reg_wr && reg_addr == olsa_pkg::ADDR_TEMP_C &&
               reg_wdata[olsa_pkg::TEMP_EN_BIT]),
    .wr_whole(reg_wr && reg_addr == olsa_pkg::ADDR_TEMP_W),
    .wr_fraction(reg_wr && reg_addr == olsa_pkg::ADDR_TEMP_F),
    .wr_data(reg_wdata),
    .conv_done(temp_done),
    .whole_in(temp_whole_in),
    .fraction_in(temp_fraction_in),
    .busy(temp_busy),
    .whole(temp_whole),
    .fraction(temp_frac),
    .start(temp_start),
    .complete(temp_cmpl)
  );

  always_comb
  begin
    mode_nxt = mode_r;
    acq_nxt = acq_r;
    led1_nxt = led1_r;
    led2_nxt = led2_r;
    led3_nxt = led3_r;
    slot_lo_nxt = slot_lo_r;
    slot_hi_nxt = slot_hi_r;
    irq_en_nxt = irq_en_r;
    flag_nxt = flag_r;
    rdata_nxt = reg_rdata;
    if (reg_wr)
    begin
      case (reg_addr)
        olsa_pkg::ADDR_MODE: mode_nxt = reg_wdata[2:0];
        olsa_pkg::ADDR_ACQ: acq_nxt = {reg_wdata[6:5],
          (reg_wdata[4:2] > rate_max(mode_r, reg_wdata[1:0])) ?
          rate_max(mode_r, reg_wdata[1:0]) : reg_wdata[4:2], reg_wdata[1:0]};
        olsa_pkg::ADDR_LED1: led1_nxt = reg_wdata;
        olsa_pkg::ADDR_LED2: led2_nxt = reg_wdata;
        olsa_pkg::ADDR_LED3: led3_nxt = reg_wdata;
        olsa_pkg::ADDR_SLOT_LO: slot_lo_nxt = reg_wdata & olsa_pkg::SLOT_MASK;
        olsa_pkg::ADDR_SLOT_HI: slot_hi_nxt = reg_wdata & olsa_pkg::SLOT_MASK;
        olsa_pkg::ADDR_INT_EN: irq_en_nxt = reg_wdata[olsa_pkg::TEMP_RDY_BIT];
        default: ;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        olsa_pkg::ADDR_INT_STAT: rdata_nxt = 8'({7'h00, flag_r} << olsa_pkg::TEMP_RDY_BIT);
        olsa_pkg::ADDR_INT_EN: rdata_nxt = 8'({7'h00, irq_en_r} << olsa_pkg::TEMP_RDY_BIT);
        olsa_pkg::ADDR_MODE: rdata_nxt = {5'h00, mode_r};
        olsa_pkg::ADDR_ACQ: rdata_nxt = {1'b0, acq_r};
        olsa_pkg::ADDR_LED1: rdata_nxt = led1_r;
        olsa_pkg::ADDR_LED2: rdata_nxt = led2_r;
        olsa_pkg::ADDR_LED3: rdata_nxt = led3_r;
        olsa_pkg::ADDR_SLOT_LO: rdata_nxt = slot_lo_r;
        olsa_pkg::ADDR_SLOT_HI: rdata_nxt = slot_hi_r;
        olsa_pkg::ADDR_TEMP_W: rdata_nxt = temp_whole;
        olsa_pkg::ADDR_TEMP_F: rdata_nxt = {4'h0, temp_frac};
        olsa_pkg::ADDR_TEMP_C: rdata_nxt = 8'({7'h00, temp_busy} << olsa_pkg::TEMP_EN_BIT);
        default: rdata_nxt = olsa_pkg::REG_RST;
      endcase
      if (reg_addr == olsa_pkg::ADDR_INT_STAT)
        flag_nxt = 1'b0;
    end
    // Setting after the read-clear keeps a completion in the same cycle.
    if (temp_cmpl)
      flag_nxt = 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      mode_r <= 3'h0;
      acq_r <= 7'h00;
      led1_r <= olsa_pkg::REG_RST;
      led2_r <= olsa_pkg::REG_RST;
      led3_r <= olsa_pkg::REG_RST;
      slot_lo_r <= olsa_pkg::REG_RST;
      slot_hi_r <= olsa_pkg::REG_RST;
      irq_en_r <= 1'b0;
      flag_r <= 1'b0;
      reg_rdata <= olsa_pkg::REG_RST;
      irq_oe_n <= 1'b1;
    end
    else
    begin
      mode_r <= mode_nxt;
      acq_r <= acq_nxt;
      led1_r <= led1_nxt;
      led2_r <= led2_nxt;
      led3_r <= led3_nxt;
      slot_lo_r <= slot_lo_nxt;
      slot_hi_r <= slot_hi_nxt;
      irq_en_r <= irq_en_nxt;
      flag_r <= flag_nxt;
      reg_rdata <= rdata_nxt;
      irq_oe_n <= !(flag_r && irq_en_r);
    end
  end

  assign pick = slot_led(mode_r, slot_lo_r, slot_hi_r, idx_r);

  // Steps after the sample start move only on microsecond ticks, so each pulse starts on a tick.
  always_comb
  begin
    st_nxt = st_r;
    idx_nxt = idx_r;
    cnt_nxt = cnt_r;
    cur_nxt = cur_r;
    push_nxt = 1'b0;
    data_nxt = fifo_data;
    unique case (st_r)
      SEQ_IDLE:
        if (sample_go && run)
        begin
          st_nxt = SEQ_PICK;
          idx_nxt = 2'h0;
        end
      SEQ_PICK:
        if (us_tick)
        begin
          if (pick != 2'h0)
          begin
            cur_nxt = pick;
            cnt_nxt = 11'h000;
            st_nxt = SEQ_PULSE;
          end
          else if (idx_r == 2'h3)
            st_nxt = SEQ_IDLE;
          else
            idx_nxt = idx_r + 2'h1;
        end
      SEQ_PULSE:
        if (us_tick)
        begin
          cnt_nxt = cnt_r + 11'h001;
          if (cnt_r == 11'(olsa_pkg::PW_US[pw] - 1))
          begin
            cur_nxt = 2'h0;
            push_nxt = 1'b1;
            data_nxt = {6'h00, adc_result & res_mask(pw)};
            st_nxt = SEQ_GAP;
          end
        end
      SEQ_GAP:
        if (us_tick)
        begin
          cnt_nxt = cnt_r + 11'h001;
          if (cnt_r == 11'(olsa_pkg::SLOT_US[pw] - 2))
          begin
            st_nxt = (idx_r == 2'h3) ? SEQ_IDLE : SEQ_PICK;
            idx_nxt = idx_r + 2'h1;
          end
        end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st_r <= SEQ_IDLE;
      idx_r <= 2'h0;
      cnt_r <= 11'h000;
      cur_r <= 2'h0;
      fifo_wr <= 1'b0;
      fifo_data <= 24'h000000;
      led_red_on <= 1'b0;
      led_ir_on <= 1'b0;
      led_green_on <= 1'b0;
      led_level <= olsa_pkg::REG_RST;
    end
    else
    begin
      st_r <= st_nxt;
      idx_r <= idx_nxt;
      cnt_r <= cnt_nxt;
      cur_r <= cur_nxt;
      fifo_wr <= push_nxt;
      fifo_data <= data_nxt;
      led_red_on <= cur_nxt == 2'h1;
      led_ir_on <= cur_nxt == 2'h2;
      led_green_on <= cur_nxt == 2'h3;
      led_level <= (cur_nxt == 2'h1) ? led1_r : (cur_nxt == 2'h2) ? led2_r :
                   (cur_nxt == 2'h3) ? led3_r : 8'h00;
    end
  end

  // Helper counters for the checks below.
  logic any_led;
  logic [14:0] on_len_r, rise_gap_r;
  assign any_led = led_red_on || led_ir_on || led_green_on;
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      on_len_r <= 15'h0000;
      rise_gap_r <= 15'h0000;
    end
    else
    begin
      on_len_r <= any_led ? on_len_r + 15'h0001 : 15'h0000;
      // Skipped slots are not counted, so only spacing between live pulses is checked.
      rise_gap_r <= (st_r == SEQ_IDLE) ? 15'h0000 :
                    (any_led && !$past(any_led)) ? 15'h0001 :
                    (rise_gap_r == 15'h0000 || (st_r == SEQ_PICK && pick == 2'h0)) ?
                    rise_gap_r : rise_gap_r + 15'h0001;
    end
  end

  sequence wr_acq_s;
    reg_wr && reg_addr == olsa_pkg::ADDR_ACQ;
  endsequence

  mode_idle_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_r == SEQ_IDLE && !run) |=> !any_led)
    else $error("LED lit in an unused mode");
  range_set_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_acq_s |=> adc_range_sel == $past(reg_wdata[6:5]))
    else $error("range field not taken from write");
  rate_clamp_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_acq_s |=> acq_r[4:2] <= rate_max(mode_r, acq_r[1:0]) &&
    (acq_r[4:2] == $past(reg_wdata[4:2]) || acq_r[4:2] == rate_max(mode_r, acq_r[1:0])))
    else $error("sample rate not clamped");
  pulse_len_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $fell(any_led) |-> $past(on_len_r) == 15'(olsa_pkg::PW_US[pw] * olsa_pkg::TICK_CYC - 1))
    else $error("pulse width wrong");
  push_end_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $fell(any_led) |-> fifo_wr ##1 !fifo_wr)
    else $error("no single push at pulse end");
  justify_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    fifo_wr |-> fifo_data[23:18] == 6'h00 && (fifo_data[17:0] & ~res_mask(pw)) == 18'h0)
    else $error("result not left-justified");
  slot_period_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(any_led) && $past(rise_gap_r) > 15'h0001 |->
    $past(rise_gap_r) == 15'(olsa_pkg::SLOT_US[pw] * olsa_pkg::TICK_CYC - 1))
    else $error("slot spacing wrong");
  green_slot_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    led_green_on |-> mode_r == olsa_pkg::MODE_SLOTS || $past(mode_r) == olsa_pkg::MODE_SLOTS)
    else $error("green lit outside slot mode");
  temp_done_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    temp_busy && temp_done |=> !temp_busy && temp_whole == $past(temp_whole_in) ##1 flag_r)
    else $error("temperature completion mishandled");
  irq_pin_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ##1 irq_oe_n == !($past(flag_r) && $past(irq_en_r)))
    else $error("interrupt pin does not follow flag");
endmodule

// [verif/olsa_front_model.sv]
// Behavioural analog front end and die-temperature sensor for the acquisition bench.
// Assumes the block's LED strobes and conversion start pulse, all on ref_clk.
`timescale 1ns/1ps
module olsa_front_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // LED strobes
  input wire logic led_red_on,
  input wire logic led_ir_on,
  input wire logic led_green_on,
  // Conversion results
  output logic [17:0] adc_result,
  // Temperature sensor
  input wire logic temp_start,
  output logic temp_done,
  output logic [7:0] temp_whole_in,
  output logic [3:0] temp_fraction_in
);
  logic [1:0] sel_r = 2'h0;
  logic [6:0] conv_cnt_r = 7'h00;
  always @(posedge ref_clk)
  begin
    if (led_red_on)
      sel_r <= 2'h1;
    else if (led_green_on)
      sel_r <= 2'h2;
    else if (led_ir_on)
      sel_r <= 2'h3;
    if (sys_rst)
      conv_cnt_r <= 7'h00;
    else if (temp_start)
      conv_cnt_r <= 7'h28;
    else if (conv_cnt_r != 7'h00)
      conv_cnt_r <= conv_cnt_r - 7'h01;
  end
  // Each LED gives its own value, held past the pulse end so a late sample still matches.
  assign adc_result = sel_r == 2'h1 ? 18'h2B5A7 : sel_r == 2'h2 ? 18'h15A5F : 18'h3C3C3;
  assign temp_done = conv_cnt_r == 7'h01;
  // Outside the done pulse the result lines carry the inverse, so a stray sample shows up.
  assign temp_whole_in = temp_done ? 8'h80 : 8'h7F;
  assign temp_fraction_in = temp_done ? 4'h8 : 4'h7;
endmodule

// [verif/test_optical_led_slot_acquisition.sv]
// Self-checking bench for the optical LED slot acquisition block.
// Assumes the front-end model file and the block's strobe register port.
`timescale 1ns/1ps
module test_optical_led_slot_acquisition;
  logic ref_clk, sys_rst, reg_wr, reg_rd, irq_o, irq_oe_n, fifo_wr;
  logic led_red_on, led_ir_on, led_green_on, temp_start, temp_done;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, led_level, temp_whole_in;
  logic [1:0] adc_range_sel, pulse_width_sel;
  logic [17:0] adc_result;
  logic [23:0] fifo_data;
  logic [3:0] temp_fraction_in;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int last_rise = 0;
  int gap = 0;
  localparam logic [7:0] RST_ADDR [9] = '{8'h0A, 8'h0C, 8'h0D, 8'h0E, 8'h11, 8'h12, 8'h1F,
    8'h20, 8'h21};
  localparam logic [2:0] RIR_MAX [4] = '{3'h6, 3'h5, 3'h4, 3'h3};
  localparam logic [2:0] HR_MAX [4] = '{3'h7, 3'h6, 3'h6, 3'h5};

  // A short sample period keeps the run brief; it still exceeds the three-pulse slot sequence configured here.
  olsa_acq_top #(.SAMPLE_CYC('{default: 35000})) DUT (.ref_clk, .sys_rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq_o, .irq_oe_n, .led_red_on, .led_ir_on,
    .led_green_on, .led_level, .adc_range_sel, .pulse_width_sel, .adc_result, .fifo_wr,
    .fifo_data, .temp_start, .temp_done, .temp_whole_in, .temp_fraction_in);
  olsa_front_model FRONT (.ref_clk, .sys_rst, .led_red_on, .led_ir_on, .led_green_on,
    .adc_result, .temp_start, .temp_done, .temp_whole_in, .temp_fraction_in);

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (err_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    @(negedge ref_clk);
    check(reg_rdata, exp);
  endtask

  task automatic slot_check(input logic [2:0] leds, input logic [7:0] lvl,
    input logic [23:0] data);
    int n;
    int w;
    n = 0;
    w = 0;
    while ({led_red_on, led_ir_on, led_green_on} === 3'b000 && n < 40000)
    begin
      @(negedge ref_clk);
      n++;
    end
    gap = cyc - last_rise;
    last_rise = cyc;
    check({led_red_on, led_ir_on, led_green_on}, leds);
    check(led_level, lvl);
    while ({led_red_on, led_ir_on, led_green_on} !== 3'b000 && w < 12000)
    begin
      @(negedge ref_clk);
      w++;
    end
    check(w, 1725);
    check(fifo_wr, 1'b1);
    check(fifo_data, data);
  endtask

  task automatic temp_run(input logic [7:0] en, input logic oe_n);
    wr(8'h03, en);
    wr(8'h21, 8'h01);
    rd(8'h21, 8'h01);
    repeat (80) @(negedge ref_clk);
    check(irq_oe_n, oe_n);
    check(irq_o, 1'b0);
    rd(8'h21, 8'h00);
    rd(8'h1F, 8'h80);
    rd(8'h20, 8'h08);
    rd(8'h01, 8'h02);
    @(negedge ref_clk);
    check(irq_oe_n, 1'b1);
    rd(8'h01, 8'h00);
  endtask

  initial
  begin
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (8) @(negedge ref_clk);
    sys_rst = 1'b0;
    foreach (RST_ADDR[i]) rd(RST_ADDR[i], 8'h00);
    wr(8'h0C, 8'h5A);
    wr(8'h0D, 8'hA5);
    wr(8'h0E, 8'hFF);
    wr(8'h0F, 8'h11);
    rd(8'h0C, 8'h5A);
    rd(8'h0D, 8'hA5);
    rd(8'h0E, 8'hFF);
    rd(8'h0F, 8'h00);
    // Slot two holds a reserved code while slot three is used, a gap software should avoid.
    wr(8'h11, 8'hD1);
    rd(8'h11, 8'h51);
    wr(8'h12, 8'h23);
    rd(8'h12, 8'h23);
    wr(8'h0A, 8'h00);
    check({led_red_on, led_ir_on, led_green_on}, 3'b000);
    wr(8'h09, 8'h07);
    slot_check(3'b100, 8'h5A, 24'h02B5A0);
    slot_check(3'b001, 8'hFF, 24'h015A58);
    slot_check(3'b010, 8'hA5, 24'h03C3C0);
    check(gap, 10675);
    for (int m = 2; m < 4; m++)
    begin
      wr(8'h09, 8'(m));
      for (int p = 0; p < 4; p++)
      begin
        wr(8'h0A, {1'b0, p[1:0], 3'h7, p[1:0]});
        rd(8'h0A, {1'b0, p[1:0], m == 2 ? HR_MAX[p] : RIR_MAX[p], p[1:0]});
        check(adc_range_sel, 24'(p));
        check(pulse_width_sel, 24'(p));
      end
    end
    wr(8'h09, 8'h02);
    rd(8'h0A, 8'h6F);
    temp_run(8'h00, 1'b1);
    temp_run(8'h02, 1'b0);
    report_and_stop();
  end
endmodule
